/* rtl/usb_packet_flag_monitor.sv */
`timescale 1ns/1ps
module usb_packet_flag_monitor
  import usb_flag_pkg::*;
(
  // clock and reset
  input  wire logic        MCLK_I,
  input  wire logic        RST_I,
  // peripheral register port
  input  wire logic [7:0]  REG_ADDR_I,
  input  wire logic        REG_WR_I,
  input  wire logic        REG_RD_I,
  input  wire logic [31:0] REG_WDATA_I,
  output logic      [31:0] REG_RDATA_O,
  // transceiver receive side
  input  wire logic [1:0]  UTMI_LINESTATE_I,
  input  wire logic        UTMI_RXACTIVE_I,
  input  wire logic        UTMI_RXVALID_I,
  input  wire logic        UTMI_RXERROR_I,
  input  wire logic [7:0]  UTMI_DATA_I,
  input  wire logic        UTMI_RXRCV_I,
  input  wire logic        UTMI_RXDP_I,
  input  wire logic        UTMI_RXDM_I,
  // transceiver direct serial control
  output logic             TX_SINGLE_ENDED_ZERO_O,
  output logic             TX_SERIAL_DATA_O,
  output logic             TX_ENABLE_N_O,
  output logic             DIRECT_SERIAL_SELECT_O,
  // notification ports
  output logic             NOTIFY_PORT_A_O,
  output logic             NOTIFY_PORT_B_O,
  output logic             NOTIFY_PORT_C_O,
  output logic             NOTIFY_PORT_D_O,
  // receive endpoint port
  output logic      [4:0]  RX_ENDPOINT_O,
  output logic             RX_ENDPOINT_VLD_O,
  // power signalling
  output logic             POWER_SIGNAL_VALID_O,
  output logic      [7:0]  POWER_SIGNAL_VALUE_O
);
  typedef struct packed {
    logic [3:0]  ser;
    logic [7:0]  ctl;
    logic [6:0]  addr;
    logic [6:0]  flags;
    logic [6:0]  sticky;
    logic [31:0] masks;
    logic [10:0] sof;
    logic [3:0]  pid;
    logic [3:0]  ep;
    logic        ep_v;
    logic [15:0] mark;
    logic [31:0] otgm;
    logic [8:0]  pwr;
    parse_type   st;
    logic [7:0]  tok1;
    logic [7:0]  tok2;
    logic        tok_sof;
    logic        act_d;
    logic [3:0]  notify;
    logic [4:0]  rx_ep;
    logic        rx_vld;
    logic [31:0] rdata;
  } state_type;

  state_type   q;
  state_type   d;
  logic [15:0] sy;
  logic [1:0]  ls;
  logic        act;
  logic        vld;
  logic        err;
  logic [7:0]  dat;
  logic [2:0]  rx_lines;
  logic        start;
  logic        stop;
  logic        bvld;
  logic [6:0]  wclr;
  logic [6:0]  lvl;
  logic [6:0]  en;
  logic [6:0]  ev;
  logic [6:0]  upd;
  logic [6:0]  f;
  logic [3:0]  ep_new;
  logic [31:0] rd_val;

  crc_feed_if crc_if ();

  // all transceiver inputs cross into the system clock here; data and
  // strobe share one pipeline so they stay aligned to each other
  line_sync #(
    .WIDTH (16)
  ) u_sync (
    .clk_i (MCLK_I),
    .rst_i (RST_I),
    .d_i   ({UTMI_LINESTATE_I, UTMI_RXACTIVE_I, UTMI_RXVALID_I,
             UTMI_RXERROR_I, UTMI_DATA_I, UTMI_RXRCV_I,
             UTMI_RXDM_I, UTMI_RXDP_I}),
    .q_o   (sy)
  );

  crc_check u_crc (
    .clk_i (MCLK_I),
    .rst_i (RST_I),
    .feed  (crc_if.crc_unit)
  );

  // unpack the synchronised bundle
  assign ls       = sy[15:14];
  assign act      = sy[13];
  assign vld      = sy[12];
  assign err      = sy[11];
  assign dat      = sy[10:3];
  assign rx_lines = sy[2:0];
  assign start    = act & ~q.act_d;
  assign stop     = ~act & q.act_d;
  assign bvld     = act & vld;
  assign ep_new   = {q.tok2[2:0], q.tok1[7]};

  // the identifier byte is not part of either checksum
  assign crc_if.clr = start;
  assign crc_if.vld = bvld & (q.st != ST_IDLE);
  assign crc_if.dat = dat;

  function automatic logic hit(input logic [7:0] off);
    return REG_WR_I && (REG_ADDR_I == off);
  endfunction

  // line state decode; bits 5:3 only set or follow the line while the decoder is enabled
  always_comb
  begin
    lvl = '0;
    lvl[SE0_STATE_FLAG]     = (ls == LINE_SE0); // see (RL7)
    lvl[K_STATE_FLAG]       = (ls == LINE_K);
    lvl[J_STATE_FLAG]       = (ls == LINE_J);
    lvl[RX_ACTIVE_FLAG]     = act; // see (RL9)
    lvl[RECEIVE_ERROR_FLAG] = err;
    en = LEVEL_FLAGS;
    if (!q.ctl[LINE_DECODER_ENABLE])
      en = LEVEL_FLAGS & ~LINE_FLAGS; // see (RL18)
  end

  // register read view; unused and reserved bits are zero
  always_comb
  begin
    rd_val = '0;
    unique case (REG_ADDR_I)
      OFF_IFM_CONTROL:      rd_val[7:0]  = q.ctl;
      OFF_DEVICE_ADDRESS:   rd_val[6:0]  = q.addr;
      OFF_SERIAL_CONTROL:   rd_val[6:0]  = {rx_lines, q.ser}; // see (RL1)
      OFF_SIGNAL_FLAGS:     rd_val[6:0]  = q.flags;
      OFF_FLAG_STICKINESS:  rd_val[6:0]  = q.sticky;
      OFF_NOTIFY_MASKS:     rd_val       = q.masks;
      OFF_FRAME_COUNT:      rd_val[10:0] = q.sof; // see (RL13)
      OFF_LAST_PACKET_ID:   rd_val[3:0]  = q.pid;
      OFF_LAST_ENDPOINT:    rd_val[4:0]  = {q.ep_v, q.ep}; // see (RL15)
      OFF_ENDPOINT_MARK:    rd_val[15:0] = q.mark;
      OFF_OTG_FLAG_MASK:    rd_val       = q.otgm;
      OFF_POWER_SIGNALLING: rd_val[8:0]  = q.pwr;
      default:              rd_val       = '0; // see (RL19)
    endcase
  end

  // next state: registers, packet parse, flags, outputs
  always_comb
  begin
    d = q;
    ev = '0;
    d.act_d = act;
    d.rx_vld = 1'b0;
    wclr = hit(OFF_SIGNAL_FLAGS) ? REG_WDATA_I[6:0] : 7'h00;
    // software writes; reserved bits never land
    if (hit(OFF_IFM_CONTROL))
      d.ctl = REG_WDATA_I[7:0] & CTL_WRITABLE; // see (RL19)
    if (hit(OFF_DEVICE_ADDRESS))
      d.addr = REG_WDATA_I[6:0];
    if (hit(OFF_SERIAL_CONTROL))
      d.ser = REG_WDATA_I[3:0]; // see (RL2) see (RL3) see (RL4)
    if (hit(OFF_FLAG_STICKINESS))
      d.sticky = REG_WDATA_I[6:0];
    if (hit(OFF_NOTIFY_MASKS))
      d.masks = REG_WDATA_I;
    if (hit(OFF_ENDPOINT_MARK))
      d.mark = REG_WDATA_I[15:0];
    if (hit(OFF_OTG_FLAG_MASK))
      d.otgm = REG_WDATA_I;
    if (hit(OFF_POWER_SIGNALLING))
      d.pwr = REG_WDATA_I[8:0];
    // packet parser; a byte arriving outside a packet is ignored
    unique case (q.st)
      ST_IDLE:
      begin
        if (bvld)
        begin
          d.pid = dat[3:0]; // see (RL14)
          d.tok_sof = (dat[3:0] == PID_SOF);
          if (dat[7:4] != ~dat[3:0])
            d.st = ST_SKIP;
          else if (dat[1:0] == PID_TOKEN_TYPE)
            d.st = ST_TOK1;
          else if (dat[1:0] == PID_DATA_TYPE)
            d.st = ST_DATA;
          else
            d.st = ST_SKIP;
        end
      end
      ST_TOK1:
      begin
        if (bvld)
        begin
          d.tok1 = dat;
          d.st = ST_TOK2;
        end
      end
      ST_TOK2:
      begin
        if (bvld)
        begin
          d.tok2 = dat;
          d.st = ST_TCHK;
        end
      end
      ST_TCHK:
      begin
        // a token longer than three bytes is not a token
        if (bvld)
          d.st = ST_SKIP;
        else if (stop && crc_if.crc5_ok)
        begin
          if (q.tok_sof)
            d.sof = {q.tok2[2:0], q.tok1}; // see (RL13)
          else if (q.tok1[6:0] == q.addr) // see (RL17)
          begin
            ev[TOKEN_RECEIVED_FLAG] = 1'b1; // see (RL6)
            d.ep = ep_new; // see (RL15)
            d.ep_v = 1'b1;
            d.rx_ep = {1'b0, ep_new} | (q.mark[ep_new] ? EP_MARK_OR : 5'h00); // see (RL16)
            d.rx_vld = 1'b1;
          end
        end
      end
      ST_DATA:
      begin
        if (stop && !crc_if.crc16_ok)
          ev[CRC16_FAIL_FLAG] = 1'b1; // see (RL8)
      end
      ST_SKIP:
      begin
        d.st = ST_SKIP;
      end
    endcase
    if (stop)
      d.st = ST_IDLE;
    // software count write wins over a frame token in the same cycle
    if (hit(OFF_FRAME_COUNT))
      d.sof = REG_WDATA_I[10:0];
    // flag update: packet start clears non-sticky, write one clears,
    // then events set so a set in the clear cycle is never lost
    f = q.flags;
    if (start)
      f = f & q.sticky; // see (RL5)
    f = f & ~wclr; // see (RL10)
    f = f | ev | (lvl & en);
    upd = ~q.sticky & en;
    f = (f & ~upd) | (lvl & upd); // see (RL11)
    d.flags = f;
    // each port ors the flags its mask selects
    for (int k = 0; k < 4; k++)
      d.notify[k] = |(q.flags & q.masks[8*k +: 7]); // see (RL12)
    if (REG_RD_I)
      d.rdata = rd_val;
  end

  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
    begin
      q <= '0;
      q.ser <= SERIAL_RESET; // see (RL3)
    end
    else
      q <= d;
  end

  // every output straight from the state register
  assign REG_RDATA_O            = q.rdata;
  assign TX_SINGLE_ENDED_ZERO_O = q.ser[TX_SE0_BIT];
  assign TX_SERIAL_DATA_O       = q.ser[TX_SERIAL_DATA_BIT];
  assign TX_ENABLE_N_O          = q.ser[TX_ENABLE_LOW_BIT];
  assign DIRECT_SERIAL_SELECT_O = q.ser[DIRECT_SERIAL_SELECT];
  assign NOTIFY_PORT_A_O        = q.notify[0];
  assign NOTIFY_PORT_B_O        = q.notify[1];
  assign NOTIFY_PORT_C_O        = q.notify[2];
  assign NOTIFY_PORT_D_O        = q.notify[3];
  assign RX_ENDPOINT_O          = q.rx_ep;
  assign RX_ENDPOINT_VLD_O      = q.rx_vld;
  assign POWER_SIGNAL_VALID_O   = q.pwr[8];
  assign POWER_SIGNAL_VALUE_O   = q.pwr[7:0];

  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (RST_I);

  // live receive lines appear in a read of the serial register
  property p_rx_lines;
    (REG_RD_I && REG_ADDR_I == OFF_SERIAL_CONTROL) |=> REG_RDATA_O[6:4] == $past(rx_lines);
  endproperty
  a_rx_lines: assert property (p_rx_lines) else $error("serial rx bits wrong"); // see (RL1)

  property p_tx_lines;
    hit(OFF_SERIAL_CONTROL) |=> TX_SINGLE_ENDED_ZERO_O == $past(REG_WDATA_I[3])
      && TX_SERIAL_DATA_O == $past(REG_WDATA_I[2]);
  endproperty
  a_tx_lines: assert property (p_tx_lines) else $error("tx se0 or data wrong"); // see (RL2)

  property p_tx_enable;
    hit(OFF_SERIAL_CONTROL) |=> TX_ENABLE_N_O == $past(REG_WDATA_I[1]);
  endproperty
  a_tx_enable: assert property (p_tx_enable) else $error("tx enable wrong"); // see (RL3)

  property p_serial_select;
    $rose(DIRECT_SERIAL_SELECT_O) |-> $past(hit(OFF_SERIAL_CONTROL) && REG_WDATA_I[0]);
  endproperty
  a_serial_select: assert property (p_serial_select) else $error("serial select bad"); // see (RL4)

  property p_start_clear;
    (start && !q.sticky[TOKEN_RECEIVED_FLAG]) |=> !q.flags[TOKEN_RECEIVED_FLAG];
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("flag kept at start"); // see (RL5)

  property p_token_flag;
    (q.st == ST_TCHK && stop && crc_if.crc5_ok && !q.tok_sof && q.tok1[6:0] == q.addr)
      |=> q.flags[TOKEN_RECEIVED_FLAG] && RX_ENDPOINT_VLD_O ##1 !RX_ENDPOINT_VLD_O;
  endproperty
  a_token_flag: assert property (p_token_flag) else $error("token not flagged"); // see (RL6)

  property p_follow_active;
    !q.sticky[RX_ACTIVE_FLAG] |=> q.flags[RX_ACTIVE_FLAG] == $past(act);
  endproperty
  a_follow_active: assert property (p_follow_active) else $error("active flag lag"); // see (RL9)

  property p_sticky_hold;
    1'b1 |=> (($past(q.flags & q.sticky & ~wclr) & ~q.flags) == 7'h00);
  endproperty
  a_sticky_hold: assert property (p_sticky_hold) else $error("sticky flag lost"); // see (RL10)

  property p_notify;
    1'b1 |=> NOTIFY_PORT_B_O == |($past(q.flags & q.masks[14:8]));
  endproperty
  a_notify: assert property (p_notify) else $error("notify port b wrong"); // see (RL12)

  property p_pid;
    (q.st == ST_IDLE && bvld) |=> q.pid == $past(dat[3:0]);
  endproperty
  a_pid: assert property (p_pid) else $error("pid not captured"); // see (RL14)

  property p_decoder_off;
    (!q.ctl[LINE_DECODER_ENABLE] && (q.flags & LINE_FLAGS) == 7'h00)
      |=> (q.flags & LINE_FLAGS) == 7'h00;
  endproperty
  a_decoder_off: assert property (p_decoder_off) else $error("line flag while off"); // see (RL18)

  property p_reserved;
    (REG_RD_I && REG_ADDR_I == OFF_SIGNAL_FLAGS) |=> REG_RDATA_O[31:7] == 25'h0000000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set"); // see (RL19)
endmodule // usb_packet_flag_monitor

/* pkg/usb_flag_pkg.sv */
// Operation
// (RL1) serial bits 6:4 show differential, minus, plus
// (RL2) bit 3 drives SE0, bit 2 transmit data
// (RL3) bit 1 is active-low transmit enable, resets 1
// (RL4) bit 0 selects direct serial mode, resets 0
// (RL5) non-sticky flags clear when a packet begins
// (RL6) flag 6 on valid addressed token
// (RL7) flags 5,4,3 for SE0, K, J line state
// (RL8) flag 2 on data packet CRC16 failure
// (RL9) flags 1,0 follow receive active and error
// (RL10) sticky flags hold until written with one
// (RL11) non-sticky flags follow later source changes
// (RL12) four masks drive four notify port outputs
// (RL13) writable 11-bit frame count, split fields
// (RL14) capture last packet identifier, reset zero
// (RL15) capture last endpoint with valid bit 4
// (RL16) marked endpoints delivered ORed with 0x10
// (RL17) accept only packets for programmed address
// (RL18) line decoding only while control bit 2 set
// (RL19) reserved bits read zero, ignore writes
package usb_flag_pkg;
  // register offsets
  localparam logic [7:0] OFF_IFM_CONTROL      = 8'h04;
  localparam logic [7:0] OFF_DEVICE_ADDRESS   = 8'h08;
  localparam logic [7:0] OFF_SERIAL_CONTROL   = 8'h18;
  localparam logic [7:0] OFF_SIGNAL_FLAGS     = 8'h1C;
  localparam logic [7:0] OFF_FLAG_STICKINESS  = 8'h20;
  localparam logic [7:0] OFF_NOTIFY_MASKS     = 8'h24;
  localparam logic [7:0] OFF_FRAME_COUNT      = 8'h28;
  localparam logic [7:0] OFF_LAST_PACKET_ID   = 8'h2C;
  localparam logic [7:0] OFF_LAST_ENDPOINT    = 8'h30;
  localparam logic [7:0] OFF_ENDPOINT_MARK    = 8'h34;
  localparam logic [7:0] OFF_OTG_FLAG_MASK    = 8'h38;
  localparam logic [7:0] OFF_POWER_SIGNALLING = 8'h3C;
  // serial control fields and reset value
  localparam int DIRECT_SERIAL_SELECT = 0;
  localparam int TX_ENABLE_LOW_BIT    = 1;
  localparam int TX_SERIAL_DATA_BIT   = 2;
  localparam int TX_SE0_BIT           = 3;
  localparam logic [3:0] SERIAL_RESET = 4'h2;
  // flag positions
  localparam int RECEIVE_ERROR_FLAG   = 0;
  localparam int RX_ACTIVE_FLAG       = 1;
  localparam int CRC16_FAIL_FLAG      = 2;
  localparam int J_STATE_FLAG         = 3;
  localparam int K_STATE_FLAG         = 4;
  localparam int SE0_STATE_FLAG       = 5;
  localparam int TOKEN_RECEIVED_FLAG  = 6;
  localparam logic [6:0] LEVEL_FLAGS  = 7'h3B;
  localparam logic [6:0] LINE_FLAGS   = 7'h38;
  // control fields
  localparam int LINE_DECODER_ENABLE  = 2;
  localparam logic [7:0] CTL_WRITABLE = 8'hF7;
  localparam logic [4:0] EP_MARK_OR   = 5'h10;
  // packet identifiers and line states
  localparam logic [1:0] PID_TOKEN_TYPE = 2'h1;
  localparam logic [1:0] PID_DATA_TYPE  = 2'h3;
  localparam logic [3:0] PID_SOF        = 4'h5;
  localparam logic [1:0] LINE_SE0       = 2'h0;
  localparam logic [1:0] LINE_J         = 2'h1;
  localparam logic [1:0] LINE_K         = 2'h2;
  // reflected crc constants, shifted lsb first
  localparam logic [4:0]  CRC5_INIT     = 5'h1F;
  localparam logic [4:0]  CRC5_POLY     = 5'h14;
  localparam logic [4:0]  CRC5_RESID    = 5'h06;
  localparam logic [15:0] CRC16_INIT    = 16'hFFFF;
  localparam logic [15:0] CRC16_POLY    = 16'hA001;
  localparam logic [15:0] CRC16_RESID   = 16'hB001;
  typedef enum logic [2:0] {
    ST_IDLE, ST_TOK1, ST_TOK2, ST_TCHK, ST_DATA, ST_SKIP
  } parse_type;
endpackage

/* pkg/crc_feed_if.sv */
`timescale 1ns/1ps
interface crc_feed_if;
  logic       clr;
  logic       vld;
  logic [7:0] dat;
  logic       crc5_ok;
  logic       crc16_ok;
  modport feeder  (output clr, vld, dat, input crc5_ok, crc16_ok);
  modport crc_unit (input clr, vld, dat, output crc5_ok, crc16_ok);
endinterface

/* rtl/line_sync.sv */
`timescale 1ns/1ps
module line_sync #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  typedef struct packed {
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s1;
  } sync_type;
  sync_type q, d;
  // only the second stage is visible outside
  always_comb
  begin
    d.s1 = d_i;
    d.s2 = q.s1;
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q <= '0;
    else
      q <= d;
  end
  assign q_o = q.s2;
endmodule // line_sync

/* rtl/crc_check.sv */
`timescale 1ns/1ps
module crc_check
  import usb_flag_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  crc_feed_if.crc_unit feed
);
  typedef struct packed {
    logic [4:0]  c5;
    logic [15:0] c16;
  } crc_type;
  crc_type q, d;
  function automatic logic [4:0] crc5_byte(input logic [4:0] c, input logic [7:0] b);
    logic [4:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
      r = (r[0] ^ b[i]) ? ((r >> 1) ^ CRC5_POLY) : (r >> 1);
    return r;
  endfunction
  function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
      r = (r[0] ^ b[i]) ? ((r >> 1) ^ CRC16_POLY) : (r >> 1);
    return r;
  endfunction
  // both sums run on every byte; the parser picks the one that fits
  always_comb
  begin
    d = q;
    if (feed.clr)
    begin
      d.c5  = CRC5_INIT;
      d.c16 = CRC16_INIT;
    end
    else if (feed.vld)
    begin
      d.c5  = crc5_byte(q.c5, feed.dat);
      d.c16 = crc16_byte(q.c16, feed.dat);
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q.c5  <= CRC5_INIT;
      q.c16 <= CRC16_INIT;
    end
    else
      q <= d;
  end
  assign feed.crc5_ok  = (q.c5 == CRC5_RESID);
  assign feed.crc16_ok = (q.c16 == CRC16_RESID);
endmodule // crc_check

/* testbench/utmi_model.sv */
`timescale 1ns/1ps
module utmi_model (
  // clock
  input  wire logic clk_i,
  // receive side toward the block
  output logic [1:0] linestate_o,
  output logic       rxactive_o,
  output logic       rxvalid_o,
  output logic       rxerror_o,
  output logic [7:0] data_o,
  output logic       rxrcv_o,
  output logic       rxdp_o,
  output logic       rxdm_o
);
  // idle full-speed bus: J on the line, receiver quiet
  initial
  begin
    linestate_o = 2'h1;
    rxactive_o  = 1'b0;
    rxvalid_o   = 1'b0;
    rxerror_o   = 1'b0;
    data_o      = 8'h00;
    rxrcv_o     = 1'b1;
    rxdp_o      = 1'b1;
    rxdm_o      = 1'b0;
  end

  // static line levels, changed away from the sampling edge
  task automatic drive_levels(input logic [1:0] ls, input logic act, input logic err,
                              input logic rcv, input logic dp, input logic dm);
    @(negedge clk_i);
    linestate_o = ls;
    rxactive_o  = act;
    rxerror_o   = err;
    rxrcv_o     = rcv;
    rxdp_o      = dp;
    rxdm_o      = dm;
  endtask

  // one packet: bytes back to back, one idle cycle, then active drops
  task automatic send_packet(input logic [31:0] bytes, input int count);
    @(negedge clk_i);
    rxactive_o = 1'b1;
    for (int i = 0; i < count; i++)
    begin
      @(negedge clk_i);
      rxvalid_o = 1'b1;
      data_o    = bytes[8*i +: 8];
    end
    @(negedge clk_i);
    rxvalid_o = 1'b0;
    data_o    = ~data_o; // a stale byte must never pass for a fresh one
    @(negedge clk_i);
    rxactive_o = 1'b0;
    repeat (8) @(negedge clk_i);
  endtask
endmodule // utmi_model

/* testbench/test_usb_packet_flag_monitor.sv */
`timescale 1ns/1ps
module test_usb_packet_flag_monitor
  import usb_flag_pkg::*;
;
  // clock, reset and register port
  logic        mclk;
  logic        rst;
  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  // transceiver side
  logic [1:0]  linestate;
  logic        rxactive;
  logic        rxvalid;
  logic        rxerror;
  logic [7:0]  rxdata;
  logic        rxrcv;
  logic        rxdp;
  logic        rxdm;
  // block outputs
  logic        tx_se0;
  logic        tx_data;
  logic        tx_en_n;
  logic        serial_sel;
  logic [3:0]  notify;
  logic [4:0]  rx_ep;
  logic        rx_ep_vld;
  logic        pwr_vld;
  logic [7:0]  pwr_val;
  // bookkeeping
  int          bad_count;
  int          checks_done;
  int          ep_pulses;
  logic [4:0]  ep_seen;

  // 200 MHz clock
  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;

  usb_packet_flag_monitor dut (
    .MCLK_I(mclk), .RST_I(rst), .REG_ADDR_I(reg_addr), .REG_WR_I(reg_wr),
    .REG_RD_I(reg_rd), .REG_WDATA_I(reg_wdata), .REG_RDATA_O(reg_rdata),
    .UTMI_LINESTATE_I(linestate), .UTMI_RXACTIVE_I(rxactive), .UTMI_RXVALID_I(rxvalid),
    .UTMI_RXERROR_I(rxerror), .UTMI_DATA_I(rxdata), .UTMI_RXRCV_I(rxrcv),
    .UTMI_RXDP_I(rxdp), .UTMI_RXDM_I(rxdm), .TX_SINGLE_ENDED_ZERO_O(tx_se0),
    .TX_SERIAL_DATA_O(tx_data), .TX_ENABLE_N_O(tx_en_n), .DIRECT_SERIAL_SELECT_O(serial_sel),
    .NOTIFY_PORT_A_O(notify[0]), .NOTIFY_PORT_B_O(notify[1]), .NOTIFY_PORT_C_O(notify[2]),
    .NOTIFY_PORT_D_O(notify[3]), .RX_ENDPOINT_O(rx_ep), .RX_ENDPOINT_VLD_O(rx_ep_vld),
    .POWER_SIGNAL_VALID_O(pwr_vld), .POWER_SIGNAL_VALUE_O(pwr_val));

  utmi_model far_end (
    .clk_i(mclk), .linestate_o(linestate), .rxactive_o(rxactive), .rxvalid_o(rxvalid),
    .rxerror_o(rxerror), .data_o(rxdata), .rxrcv_o(rxrcv), .rxdp_o(rxdp), .rxdm_o(rxdm));

  // endpoint pulses are one cycle wide, so look mid-cycle
  always @(negedge mclk)
    if (rx_ep_vld === 1'b1)
    begin
      ep_pulses++;
      ep_seen = rx_ep;
    end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one-cycle strobes launched on the falling edge
  task automatic reg_write(input logic [7:0] addr, input logic [31:0] data);
    reg_addr  = addr;
    reg_wdata = data;
    reg_wr    = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
    // one idle edge, so back-to-back writes never retoggle the strobe in one step
    @(negedge mclk);
  endtask

  // read data holds until the next read, so one extra cycle is safe
  task automatic read_check(input string what, input logic [7:0] addr, input logic [31:0] exp);
    reg_addr = addr;
    reg_rd   = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    @(negedge mclk);
    check(what, exp, reg_rdata);
  endtask

  // token tail byte: crc5 over 11 bits lsb first, sent inverted
  function automatic logic [7:0] token_tail(input logic [10:0] v);
    logic [4:0] crc;
    crc = 5'h1F;
    for (int i = 0; i < 11; i++)
      crc = (crc[0] ^ v[i]) ? ((crc >> 1) ^ 5'h14) : (crc >> 1);
    return {~crc, v[10:8]};
  endfunction

  task automatic send_token(input logic [7:0] pid, input logic [10:0] v);
    far_end.send_packet({8'h00, token_tail(v), v[7:0], pid}, 3);
  endtask

  task automatic test_reset_values();
    read_check("serial control", 8'h18, 32'h0000_0052);
    for (int a = 8'h1C; a <= 8'h3C; a += 4)
      read_check("reset register", a[7:0], 32'h0);
    read_check("unmapped", 8'h44, 32'h0);
    check("serial pins", 32'h2, {tx_se0, tx_data, tx_en_n, serial_sel});
    $display("reset values test done");
  endtask

  task automatic test_serial();
    reg_write(8'h18, 32'hFFFF_FFFF);
    check("serial pins", 32'hF, {tx_se0, tx_data, tx_en_n, serial_sel});
    read_check("serial control", 8'h18, 32'h0000_005F);
    far_end.drive_levels(2'h1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    repeat (4) @(negedge mclk);
    read_check("serial rx lines", 8'h18, 32'h0000_002F);
    reg_write(8'h18, 32'h0000_0009);
    check("serial pins", 32'h9, {tx_se0, tx_data, tx_en_n, serial_sel});
    reg_write(8'h18, 32'h0000_0004);
    check("serial pins", 32'h4, {tx_se0, tx_data, tx_en_n, serial_sel});
    far_end.drive_levels(2'h1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    $display("serial control test done");
  endtask

  task automatic test_token();
    reg_write(8'h08, 32'hFFFF_FFAA);
    read_check("device address", 8'h08, 32'h2A);
    reg_write(8'h34, 32'h0000_0020);
    ep_pulses = 0;
    send_token(8'h69, {4'h5, 7'h2A});
    check("endpoint pulses", 32'd1, ep_pulses);
    check("endpoint port", 32'h15, ep_seen);
    read_check("flags", 8'h1C, 32'h40);
    read_check("endpoint", 8'h30, 32'h15);
    read_check("packet ident", 8'h2C, 32'h9);
    send_token(8'hE1, {4'h3, 7'h2B});
    check("endpoint pulses", 32'd1, ep_pulses);
    read_check("flags", 8'h1C, 32'h0);
    read_check("endpoint", 8'h30, 32'h15);
    read_check("packet ident", 8'h2C, 32'h1);
    send_token(8'hE1, {4'h3, 7'h2A});
    check("endpoint port", 32'h03, ep_seen);
    read_check("endpoint", 8'h30, 32'h13);
    send_token(8'hA5, 11'h523);
    read_check("frame count", 8'h28, 32'h523);
    read_check("flags", 8'h1C, 32'h0);
    check("endpoint pulses", 32'd2, ep_pulses);
    $display("token test done");
  endtask

  task automatic test_crc16();
    far_end.send_packet(32'h3322_11C3, 4);
    read_check("flags", 8'h1C, 32'h04);
    far_end.send_packet(32'h0000_00C3, 3);
    read_check("flags", 8'h1C, 32'h00);
    $display("crc16 test done");
  endtask

  task automatic test_sticky();
    reg_write(8'h20, 32'hFFFF_FF44);
    read_check("stickiness", 8'h20, 32'h44);
    send_token(8'h69, {4'h5, 7'h2A});
    far_end.send_packet(32'h3322_11C3, 4);
    read_check("flags", 8'h1C, 32'h44);
    reg_write(8'h1C, 32'h0000_0004);
    read_check("flags", 8'h1C, 32'h40);
    reg_write(8'h1C, 32'h0000_0040);
    read_check("flags", 8'h1C, 32'h00);
    reg_write(8'h20, 32'h0);
    $display("sticky test done");
  endtask

  task automatic test_lines();
    logic [1:0] ls [3];
    logic [6:0] fl [3];
    ls = '{2'h0, 2'h1, 2'h2};
    fl = '{7'h20, 7'h08, 7'h10};
    far_end.drive_levels(2'h2, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    repeat (6) @(negedge mclk);
    read_check("flags", 8'h1C, 32'h0);
    reg_write(8'h04, 32'h0000_0004);
    for (int i = 0; i < 3; i++)
    begin
      far_end.drive_levels(ls[i], 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
      repeat (6) @(negedge mclk);
      read_check("line flags", 8'h1C, {25'h0, fl[i]});
    end
    far_end.drive_levels(2'h2, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
    reg_write(8'h24, 32'h0208_1001);
    repeat (6) @(negedge mclk);
    read_check("flags", 8'h1C, 32'h13);
    check("notify ports", 32'hB, notify);
    read_check("masks", 8'h24, 32'h0208_1001);
    far_end.drive_levels(2'h1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
    repeat (6) @(negedge mclk);
    check("notify ports", 32'h4, notify);
    reg_write(8'h04, 32'h0);
    reg_write(8'h24, 32'h0);
    $display("line state test done");
  endtask

  task automatic test_misc();
    reg_write(8'h28, 32'hFFFF_FFFF);
    read_check("frame count", 8'h28, 32'h7FF);
    reg_write(8'h3C, 32'hFFFF_FFFF);
    read_check("power", 8'h3C, 32'h1FF);
    check("power pins", 32'h1FF, {pwr_vld, pwr_val});
    reg_write(8'h3C, 32'h0000_00AB);
    check("power pins", 32'h0AB, {pwr_vld, pwr_val});
    reg_write(8'h38, 32'hA5A5_A5A5);
    read_check("otg mask", 8'h38, 32'hA5A5_A5A5);
    reg_write(8'h34, 32'hFFFF_FFFF);
    read_check("endpoint mark", 8'h34, 32'hFFFF);
    reg_write(8'h2C, 32'hFFFF_FFFF);
    read_check("packet ident", 8'h2C, 32'h3);
    $display("misc register test done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // the run takes a few hundred cycles; 40000 means a hang
  initial
  begin
    #200000;
    bad_count++;
    end_of_test();
  end

  initial
  begin
    bad_count   = 0;
    checks_done = 0;
    ep_pulses   = 0;
    ep_seen     = 5'h00;
    rst         = 1'b1;
    reg_addr    = 8'h00;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    reg_wdata   = 32'h0;
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    // the line synchroniser is cleared by reset and needs two edges to refill
    repeat (2) @(negedge mclk);
    test_reset_values();
    test_serial();
    test_token();
    test_crc16();
    test_sticky();
    test_lines();
    test_misc();
    end_of_test();
  end
endmodule // test_usb_packet_flag_monitor
